// file: verification/testbench.sv
// self-checking bench for the video ram arbiter
`timescale 1ns/100ps
module testbench;
  localparam int DIV = 4;
  logic mclk_in, rst_in, sel, wr, mrd, svs, bcyc, fill, flvl, rdy, pen;
  logic [15:0] haddr, daddr;
  logic [7:0] wbus, wdat, rdata, maddr, tcnt;
  logic [2:0] wgate, rsel, ras_n, pr;
  logic [3:0] crow;
  logic wait_n, owns, tick, tick_i, strobe, pcap, rcs, cas_n, we_n, dvalid, tk_seen;
  vra_pkg::vra_pix_t ram_rd, disp;
  vra_pkg::vra_pen_t pen_lat;
  logic [7:0] ex [3];
  int n_mismatch, n_checks, cyc, n, m;

  vra_top #(.PIX_DIV(DIV)) DUT (
    .mclk_in                  (mclk_in),
    .rst_in                   (rst_in),
    .host_vram_request_sel_in (sel),
    .bus_mem_write_strobe_in  (wr),
    .memory_read_status_in    (mrd),
    .status_valid_sync_in     (svs),
    .host_bus_cycle_in        (bcyc),
    .host_addr_in             (haddr),
    .host_write_bus_in        (wbus),
    .write_gate_in            (wgate),
    .read_sel_in              (rsel),
    .vram_wait_n_out          (wait_n),
    .host_read_data_out       (rdata),
    .host_owns_vram_out       (owns),
    .fill_screen_cmd_in       (fill),
    .fill_level_in            (flvl),
    .vram_full_addr_in        (daddr),
    .char_row_lines_in        (crow),
    .pixel_tick_out           (tick),
    .pixel_tick_inv_out       (tick_i),
    .display_latch_strobe_out (strobe),
    .pen_capture_out          (pcap),
    .vram_mux_addr_out        (maddr),
    .row_col_select_out       (rcs),
    .ras_n_out                (ras_n),
    .cas_n_out                (cas_n),
    .we_n_out                 (we_n),
    .ram_wdata_out            (wdat),
    .ram_rdata_in             (ram_rd),
    .disp_data_out            (disp),
    .disp_valid_out           (dvalid),
    .disp_ready_in            (rdy),
    .pen_strobe_in            (pen),
    .pen_latch_out            (pen_lat)
  );

  vra_ram_model #(.HOLD(DIV)) ram (
    .mclk_in     (mclk_in),
    .mux_addr_in (maddr),
    .ras_n_in    (ras_n),
    .cas_n_in    (cas_n),
    .we_n_in     (we_n),
    .wdata_in    (wdat),
    .rdata_out   (ram_rd)
  );

  // *****
  // compare and closing tasks
  // *****
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic pulse_bus();
    @(negedge mclk_in);
    bcyc = 1'b1;
    @(negedge mclk_in);
    bcyc = 1'b0;
  endtask

  // one host access, select held until the wait is released
  task automatic host_access(input logic w, input logic [2:0] g, input logic [2:0] rs,
                             input logic [15:0] a, input logic [7:0] d);
    int k;
    logic seen;
    @(negedge mclk_in);
    haddr = a;
    wbus = d;
    wgate = g;
    rsel = rs;
    wr = w;
    mrd = !w;
    svs = !w;
    sel = 1'b1;
    @(negedge mclk_in);
    svs = 1'b0;
    pulse_bus();
    chk_bit(wait_n, 1'b1);
    pulse_bus();
    chk_bit(wait_n, 1'b0);
    k = 0;
    seen = 1'b0;
    while (wait_n !== 1'b1 && k < 400) begin
      @(negedge mclk_in);
      seen = seen | (owns === 1'b1);
      k++;
    end
    chk_bit(seen, 1'b1);
    chk_bit(wait_n, 1'b1);
    sel = 1'b0;
    wr = 1'b0;
    mrd = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk_bit(owns, 1'b0);
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // *****
  // monitors and timeout
  // *****
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  always @(negedge mclk_in) begin
    if (rst_in === 1'b0) begin
      if (cas_n === 1'b0) chk_bit(rcs, 1'b1);
      if (owns === 1'b0 && ras_n !== 3'h7) chk_byte({5'h0, ras_n}, 8'h00);
      if (owns === 1'b1) chk_bit(strobe, 1'b0);
      if (tick === 1'b1) chk_bit(tick_i, 1'b0);
      if (tick === 1'b1 && tk_seen) chk_byte(tcnt, 8'(DIV));
      if (tick === 1'b1) begin
        tk_seen = 1'b1;
        tcnt = 8'h00;
      end
      tcnt++;
    end
  end

  initial begin
    {sel, wr, mrd, svs, bcyc, fill, flvl, pen, tk_seen} = '0;
    rdy = 1'b1;
    rst_in = 1'b1;
    haddr = 16'h0000;
    daddr = 16'h1234;
    wbus = 8'h00;
    wgate = 3'h0;
    rsel = 3'h0;
    crow = 4'h0;
    tcnt = 8'h00;
    repeat (16) @(negedge mclk_in);
    chk_byte({5'h0, ras_n}, 8'h07);
    chk_bit(wait_n, 1'b1);
    chk_bit(owns, 1'b0);
    chk_bit(dvalid, 1'b0);
    chk_byte(pen_lat, 8'h00);
    rst_in = 1'b0;
    pulse_bus();
    pulse_bus();
    chk_bit(wait_n, 1'b1);
    repeat (50) @(negedge mclk_in);
    n = 0;
    m = 0;
    pr = ras_n;
    repeat (960) begin
      @(negedge mclk_in);
      if (ras_n === 3'h0 && pr === 3'h7) n++;
      if (strobe === 1'b1) m++;
      pr = ras_n;
    end
    chk_byte(n[7:0], 8'h14);
    chk_byte(m[7:0], 8'h14);
    host_access(1'b1, 3'h5, 3'h0, 16'h3c5a, 8'ha5);
    host_access(1'b1, 3'h2, 3'h0, 16'h3c5a, 8'h3c);
    ex = '{8'ha5, 8'h3c, 8'ha5};
    for (int b = 0; b < 3; b++) begin
      host_access(1'b0, 3'h0, 3'h1 << b, 16'h3c5a, 8'h00);
      chk_byte(rdata, ex[b]);
    end
    fill = 1'b1;
    repeat (300) @(negedge mclk_in);
    chk_byte(wdat, 8'h00);
    chk_bit(we_n, 1'b0);
    flvl = 1'b1;
    repeat (300) @(negedge mclk_in);
    chk_byte(wdat, 8'hff);
    chk_bit(we_n, 1'b0);
    fill = 1'b0;
    for (int b = 0; b < 3; b++) begin
      host_access(1'b0, 3'h0, 3'h1 << b, 16'h1234, 8'h00);
      chk_byte(rdata, 8'hff);
    end
    // display stall: buffer fills, ring stops, two words drain
    rdy = 1'b0;
    repeat (300) @(negedge mclk_in);
    chk_bit(dvalid, 1'b1);
    for (int b = 0; b < 3; b++) chk_byte(disp[8*b +: 8], 8'hff);
    n = 0;
    repeat (200) begin
      @(negedge mclk_in);
      if (ras_n !== 3'h7) n++;
    end
    chk_byte(n[7:0], 8'h00);
    rdy = 1'b1;
    @(negedge mclk_in);
    chk_bit(dvalid, 1'b1);
    @(negedge mclk_in);
    chk_bit(dvalid, 1'b0);
    crow = 4'ha;
    pen = 1'b1;
    n = 0;
    while (pcap !== 1'b1 && n < 100) begin
      @(negedge mclk_in);
      n++;
    end
    chk_bit(pcap, 1'b1);
    @(negedge mclk_in);
    chk_byte({4'h0, pen_lat.row}, 8'h0a);
    m = 0;
    repeat (60) begin
      @(negedge mclk_in);
      if (pcap === 1'b1) m++;
    end
    chk_byte(m[7:0], 8'h00);
    report_and_stop();
  end
endmodule

// file: verification/vra_ram_model.sv
// three-bank video ram model facing the arbiter's ram pins
`timescale 1ns/100ps
module vra_ram_model #(
  parameter int HOLD = 4
) (
  // ram pins
  input  wire logic        mclk_in,
  input  wire logic [7:0]  mux_addr_in,
  input  wire logic [2:0]  ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [7:0]  wdata_in,
  output vra_pkg::vra_pix_t rdata_out
);
  logic [7:0] mem [3][65536];
  logic [7:0] row_r [3];
  logic [7:0] rd_r [3];
  int         hold_r [3];
  logic [2:0] ras_d_r;
  logic       cas_d_r;

  initial begin
    for (int b = 0; b < 3; b++) begin
      for (int a = 0; a < 65536; a++) begin
        mem[b][a] = 8'h00;
      end
      rd_r[b] = 8'h00;
      hold_r[b] = 0;
    end
  end

  assign rdata_out = {rd_r[2], rd_r[1], rd_r[0]};

  // *****
  // row taken at row strobe fall; column only once the mux address settled
  // *****
  always @(posedge mclk_in) begin
    ras_d_r <= ras_n_in;
    cas_d_r <= cas_n_in;
    for (int b = 0; b < 3; b++) begin
      if (!ras_n_in[b] && ras_d_r[b]) begin
        row_r[b] <= mux_addr_in;
      end
      if (!cas_n_in && !cas_d_r && !ras_n_in[b]) begin
        hold_r[b] <= 0;
        if (!we_n_in) begin
          mem[b][{mux_addr_in, row_r[b]}] <= wdata_in;
        end else begin
          rd_r[b] <= mem[b][{mux_addr_in, row_r[b]}];
        end
      end else if (hold_r[b] < HOLD) begin
        hold_r[b] <= hold_r[b] + 1;
      end else begin
        // released output: changes every cycle
        rd_r[b] <= ~rd_r[b];
      end
    end
  end
endmodule

// file: verilog/vra_pkg.sv
// constants, types and phase map of the video ram arbiter
// Notes on behaviour
// - three colour banks; host reads/writes, display reads
// - host write strobes only write-gated banks
// - address muxed; select low row, high column
// - display ownership strobes all three banks together
// - fill drives all-ones or all-zeros data
// - fill holds write enable on every bank
// - pixel tick and inverse from one reference
// - ring counter phases, odd phases on inverse
// - three slots: two display, one host
// - display portion starts at first phase fall
// - host slot row strobes only on request; column strobe runs in every slot
// - no display latch strobe in host slot
// - wait asserted after second host bus cycle
// - no wait for non-video host accesses
// - display always has priority over host
// - write requests directly; read captured on sync
// - grant latched at mid phase rising edge
// - late phase latches read data, releases wait
// - select drop clears request, grant, done flag and bus cycle count; read data latch holds
// - pen strobe synchronised, rising pulse captures
// - pen latch holds row lines and position
package vra_pkg;

  // ******************************************************
  // clock and timing
  // ******************************************************
  localparam int CLK_KHZ     = 100000;
  localparam int PIX_KHZ     = 14112;
  localparam int PIX_DIV     = CLK_KHZ / PIX_KHZ;
  localparam int RING_LEN    = 8;
  localparam int SLOTS       = 3;
  localparam int BUS_CYC_WAIT = 2;

  // ******************************************************
  // ring phase positions
  // ******************************************************
  localparam int PH_Q0       = 0;
  localparam int PH_Q10      = 1;
  localparam int PH_RAS_ON   = 2;
  localparam int PH_CAS_ON   = 3;
  localparam int PH_CAS_OFF  = 5;
  localparam int PH_Q60      = 6;
  localparam logic [1:0] SLOT_HOST = 2'h2;
  localparam logic [1:0] SLOT_LAST = 2'h2;

  // ******************************************************
  // banks and widths
  // ******************************************************
  localparam int BANKS   = 3;
  localparam int BANK_R  = 0;
  localparam int BANK_G  = 1;
  localparam int BANK_B  = 2;
  localparam int ADDR_W  = 16;
  localparam int MUX_W   = 8;
  localparam int DATA_W  = 8;
  localparam int POS_W   = 4;
  localparam int ROW_W   = 4;
  localparam logic [3:0] POS_INIT = 4'hf;

  typedef struct packed {
    logic [DATA_W-1:0] blue;
    logic [DATA_W-1:0] green;
    logic [DATA_W-1:0] red;
  } vra_pix_t;

  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic [POS_W-1:0] pos;
  } vra_pen_t;

endpackage

// file: verilog/vra_top.sv
// video ram arbiter: phase generator, strobes, host arbitration, pen capture
`timescale 1ns/100ps
module vra_top #(
  parameter int PIX_DIV = vra_pkg::PIX_DIV
) (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        rst_in,
  // host bus side
  input  wire logic                        host_vram_request_sel_in,
  input  wire logic                        bus_mem_write_strobe_in,
  input  wire logic                        memory_read_status_in,
  input  wire logic                        status_valid_sync_in,
  input  wire logic                        host_bus_cycle_in,
  input  wire logic [vra_pkg::ADDR_W-1:0]  host_addr_in,
  input  wire logic [vra_pkg::DATA_W-1:0]  host_write_bus_in,
  input  wire logic [vra_pkg::BANKS-1:0]   write_gate_in,
  input  wire logic [vra_pkg::BANKS-1:0]   read_sel_in,
  output logic                             vram_wait_n_out,
  output logic [vra_pkg::DATA_W-1:0]       host_read_data_out,
  output logic                             host_owns_vram_out,
  // fill control
  input  wire logic                        fill_screen_cmd_in,
  input  wire logic                        fill_level_in,
  // display controller side
  input  wire logic [vra_pkg::ADDR_W-1:0]  vram_full_addr_in,
  input  wire logic [vra_pkg::ROW_W-1:0]   char_row_lines_in,
  output logic                             pixel_tick_out,
  output logic                             pixel_tick_inv_out,
  output logic                             display_latch_strobe_out,
  output logic                             pen_capture_out,
  // video ram pins
  output logic [vra_pkg::MUX_W-1:0]        vram_mux_addr_out,
  output logic                             row_col_select_out,
  output logic [vra_pkg::BANKS-1:0]        ras_n_out,
  output logic                             cas_n_out,
  output logic                             we_n_out,
  output logic [vra_pkg::DATA_W-1:0]       ram_wdata_out,
  input  wire vra_pkg::vra_pix_t           ram_rdata_in,
  // display data stream
  output vra_pkg::vra_pix_t                disp_data_out,
  output logic                             disp_valid_out,
  input  wire logic                        disp_ready_in,
  // light pen
  input  wire logic                        pen_strobe_in,
  output vra_pkg::vra_pen_t                pen_latch_out
);

  generate
    if (PIX_DIV < 2) begin : g_bad_div
      $error("PIX_DIV must be at least 2");
    end
  endgenerate

  localparam int DW = $clog2(PIX_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(PIX_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(PIX_DIV / 2);

  // ******************************************************
  // pixel tick divider
  // ******************************************************
  logic [DW-1:0] div_r;
  wire           tick_w     = (div_r == DIV_LAST);
  wire           tick_inv_w = (div_r == DIV_HALF);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= '0;
    end else begin
      div_r <= tick_w ? '0 : DW'(div_r + 1'b1);
    end
  end

  assign pixel_tick_out     = tick_w;
  assign pixel_tick_inv_out = tick_inv_w;

  // ******************************************************
  // display buffer, two entries
  // ******************************************************
  vra_pkg::vra_pix_t buf_r [2];
  logic              wr_ptr_r;
  logic              rd_ptr_r;
  logic [1:0]        cnt_r;
  wire               buf_full_w  = (cnt_r == 2'h2);
  wire               buf_push_w;
  wire               buf_pop_w   = disp_valid_out & disp_ready_in;

  assign disp_valid_out = (cnt_r != 2'h0);
  assign disp_data_out  = buf_r[rd_ptr_r];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ buf_push_w;
      rd_ptr_r <= rd_ptr_r ^ buf_pop_w;
      cnt_r    <= 2'(cnt_r + {1'b0, buf_push_w} - {1'b0, buf_pop_w});
    end
  end

  always_ff @(posedge mclk_in) begin
    if (buf_push_w) begin
      buf_r[wr_ptr_r] <= ram_rdata_in;
    end
  end

  // ******************************************************
  // ring counter and slot counter
  // ******************************************************
  logic [vra_pkg::RING_LEN-1:0] ring_r;
  logic [vra_pkg::RING_LEN-1:0] odd_r;
  logic [1:0]                   slot_r;
  wire  adv_w     = tick_w & ~buf_full_w; // full buffer stalls the timing
  wire  wrap_w    = ring_r[vra_pkg::RING_LEN-1];
  wire  host_slot = (slot_r == vra_pkg::SLOT_HOST);
  wire  [vra_pkg::RING_LEN-1:0] odd_rise_w = ring_r & ~odd_r;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ring_r <= 8'h01;
      slot_r <= 2'h0;
    end else if (adv_w) begin
      ring_r <= {ring_r[vra_pkg::RING_LEN-2:0], wrap_w};
      if (wrap_w) begin
        slot_r <= (slot_r == vra_pkg::SLOT_LAST) ? 2'h0 : 2'(slot_r + 1'b1);
      end
    end
  end

  // odd phases trail the ring by half a pixel
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      odd_r <= 8'h01;
    end else if (tick_inv_w) begin
      odd_r <= ring_r;
    end
  end

  wire q15_rise_w = tick_inv_w & odd_rise_w[vra_pkg::PH_Q10] & host_slot;
  wire q65_rise_w = tick_inv_w & odd_rise_w[vra_pkg::PH_Q60] & host_slot;

  // ******************************************************
  // strobe phases
  // ******************************************************
  // display portion opens as phase zero falls, at slot 0 phase 1
  wire disp_start_w = adv_w & ring_r[vra_pkg::PH_Q0] & (slot_r == 2'h0);
  wire ras_ph_w = |ring_r[vra_pkg::PH_CAS_OFF:vra_pkg::PH_RAS_ON];
  wire cas_ph_w = |ring_r[vra_pkg::PH_CAS_OFF:vra_pkg::PH_CAS_ON];

  assign display_latch_strobe_out = adv_w & ring_r[vra_pkg::PH_Q60] & ~host_slot;
  assign buf_push_w               = display_latch_strobe_out;

  // ******************************************************
  // host request and arbitration
  // ******************************************************
  logic       rd_cap_r;
  logic       grant_r;
  logic       done_r;
  logic [1:0] bcyc_r;
  wire        sel_w  = host_vram_request_sel_in;
  wire        req_w  = sel_w & (bus_mem_write_strobe_in | rd_cap_r);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_cap_r <= 1'b0;
      grant_r  <= 1'b0;
      done_r   <= 1'b0;
      bcyc_r   <= 2'h0;
    end else if (!sel_w) begin
      rd_cap_r <= 1'b0;
      grant_r  <= 1'b0;
      done_r   <= 1'b0;
      bcyc_r   <= 2'h0;
    end else begin
      if (status_valid_sync_in && memory_read_status_in) begin
        rd_cap_r <= 1'b1;
      end
      if (q15_rise_w && req_w && !grant_r) begin
        grant_r <= 1'b1;
      end
      if (q65_rise_w && grant_r) begin
        done_r <= 1'b1;
      end
      if (host_bus_cycle_in && bcyc_r != 2'(vra_pkg::BUS_CYC_WAIT)) begin
        bcyc_r <= 2'(bcyc_r + 1'b1);
      end
    end
  end

  // host owns the memory only inside its own slot
  wire host_owns_w = grant_r & ~done_r & host_slot;
  assign host_owns_vram_out = host_owns_w;

  // wait only for a video access, from the second bus cycle
  assign vram_wait_n_out = ~(sel_w & ~done_r &
                             (bcyc_r == 2'(vra_pkg::BUS_CYC_WAIT)));

  // ******************************************************
  // host read latch, relies on a one-hot select
  // ******************************************************
  wire [vra_pkg::DATA_W-1:0] rd_mux_w =
    read_sel_in[vra_pkg::BANK_R] ? ram_rdata_in.red   :
    read_sel_in[vra_pkg::BANK_G] ? ram_rdata_in.green :
                                   ram_rdata_in.blue;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      host_read_data_out <= '0;
    end else if (q65_rise_w && grant_r && !bus_mem_write_strobe_in) begin
      host_read_data_out <= rd_mux_w;
    end
  end

  // ******************************************************
  // row strobes per bank
  // ******************************************************
  wire host_wr_w = bus_mem_write_strobe_in;
  genvar b;
  generate
    for (b = 0; b < vra_pkg::BANKS; b++) begin : g_bank
      wire host_gate_w = host_wr_w ? write_gate_in[b] : read_sel_in[b];
      wire gate_w      = host_slot ? (host_owns_w & host_gate_w) : 1'b1;
      assign ras_n_out[b] = ~(ras_ph_w & gate_w);
    end
  endgenerate

  assign cas_n_out          = ~cas_ph_w;
  assign row_col_select_out = cas_ph_w;

  // ******************************************************
  // write enable and write data
  // ******************************************************
  assign we_n_out = ~(fill_screen_cmd_in | (host_owns_w & host_wr_w));

  wire [vra_pkg::DATA_W-1:0] wdata_w =
    fill_screen_cmd_in ? {vra_pkg::DATA_W{fill_level_in}} : host_write_bus_in;

  wire [vra_pkg::ADDR_W-1:0] addr_w = host_owns_w ? host_addr_in : vram_full_addr_in;
  wire [vra_pkg::MUX_W-1:0]  mux_w  = cas_ph_w ? addr_w[vra_pkg::ADDR_W-1:vra_pkg::MUX_W]
                                               : addr_w[vra_pkg::MUX_W-1:0];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ram_wdata_out     <= '0;
      vram_mux_addr_out <= '0;
    end else begin
      ram_wdata_out     <= wdata_w;
      vram_mux_addr_out <= mux_w;
    end
  end

  // ******************************************************
  // light pen
  // ******************************************************
  logic                      pen_s1_r;
  logic                      pen_s2_r;
  logic                      pen_s3_r;
  logic [vra_pkg::POS_W-1:0] pos_r;
  wire                       pen_rise_w = pen_s2_r & ~pen_s3_r;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pen_s1_r <= 1'b0;
      pen_s2_r <= 1'b0;
      pen_s3_r <= 1'b0;
      pos_r    <= vra_pkg::POS_INIT;
    end else if (tick_w) begin
      pen_s1_r <= pen_strobe_in;
      pen_s2_r <= pen_s1_r;
      pen_s3_r <= pen_s2_r;
      pos_r    <= 4'(pos_r - 1'b1);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pen_capture_out <= 1'b0;
      pen_latch_out   <= '0;
    end else begin
      pen_capture_out <= tick_w & pen_rise_w;
      if (tick_w && pen_rise_w) begin
        pen_latch_out <= '{row: char_row_lines_in, pos: pos_r};
      end
    end
  end

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_q65;
    q65_rise_w && grant_r;
  endsequence

  property p_fill_we;
    fill_screen_cmd_in |-> !we_n_out;
  endproperty
  a_fill_we: assert property (p_fill_we) else $error("fill without write");

  property p_fill_data;
    fill_screen_cmd_in |=> ram_wdata_out == {vra_pkg::DATA_W{$past(fill_level_in)}};
  endproperty
  a_fill_data: assert property (p_fill_data) else $error("fill data wrong");

  property p_disp_all;
    (!host_slot && ras_ph_w) |-> ras_n_out == 3'h0;
  endproperty
  a_disp_all: assert property (p_disp_all) else $error("display ras not all");

  property p_host_gate;
    (host_owns_w && host_wr_w && ras_ph_w) |-> ras_n_out == ~write_gate_in;
  endproperty
  a_host_gate: assert property (p_host_gate) else $error("host ras gate");

  property p_no_req_ras;
    (host_slot && !grant_r) |-> ras_n_out == 3'h7;
  endproperty
  a_no_req_ras: assert property (p_no_req_ras) else $error("ras without request");

  property p_strobe_slot;
    display_latch_strobe_out |-> !host_slot && cas_n_out && ras_n_out == 3'h7;
  endproperty
  a_strobe_slot: assert property (p_strobe_slot) else $error("strobe in host slot");

  property p_rowcol;
    (!cas_n_out |-> row_col_select_out) and (!row_col_select_out |-> cas_n_out);
  endproperty
  a_rowcol: assert property (p_rowcol) else $error("row column select");

  property p_release;
    s_q65 |=> vram_wait_n_out;
  endproperty
  a_release: assert property (p_release) else $error("wait not released");

  property p_nonvideo;
    !sel_w |-> vram_wait_n_out;
  endproperty
  a_nonvideo: assert property (p_nonvideo) else $error("wait on non-video");

  property p_drop;
    $fell(sel_w) |=> !grant_r && !done_r && !host_owns_vram_out;
  endproperty
  a_drop: assert property (p_drop) else $error("select drop not cleared");

  property p_owns;
    host_owns_vram_out |-> host_slot && grant_r && sel_w;
  endproperty
  a_owns: assert property (p_owns) else $error("host owns outside slot");

  property p_pen;
    (tick_w && pen_rise_w) |=> pen_capture_out && pen_latch_out.pos == $past(pos_r);
  endproperty
  a_pen: assert property (p_pen) else $error("pen latch wrong");

  // one cycle after phase zero falls: phase one of a display slot, no strobe yet
  sequence s_disp_open;
    ring_r[vra_pkg::PH_Q10] && !host_slot && ras_n_out == 3'h7;
  endsequence

  property p_start;
    disp_start_w |=> s_disp_open;
  endproperty
  a_start: assert property (p_start) else $error("display start phase");

endmodule
